// ### pwmt_regs.vh
// Register map, field positions and reset values of the pulse width timer.
// Included by every design file of the block; definitions only.
`ifndef PWMT_REGS_VH
`define PWMT_REGS_VH

// Register addresses
`define PWMT_ADDR_MODE      4'h0
`define PWMT_ADDR_PRESCALE  4'h1
`define PWMT_ADDR_COUNTER   4'h2
`define PWMT_ADDR_PINCFG    4'h3
`define PWMT_ADDR_IRQ_STAT  4'h4
`define PWMT_ADDR_IRQ_CLR   4'h5
`define PWMT_ADDR_IRQ_EN    4'h6

// Mode register fields
`define PWMT_MODE_POL_BIT   0
`define PWMT_MODE_RUN_BIT   1
`define PWMT_MODE_SRC_LSB   2
`define PWMT_MODE_SRC_MSB   3

// Pin configuration field
`define PWMT_PINCFG_SEL_BIT 0

// Interrupt status fields
`define PWMT_IRQ_UF_BIT     0
`define PWMT_IRQ_EDGE_BIT   1
`define PWMT_IRQ_W          2

// Count source codes
`define PWMT_SRC_UNDIV      2'h0
`define PWMT_SRC_HALF       2'h1
`define PWMT_SRC_EIGHTH     2'h2
`define PWMT_SRC_RING       2'h3

// Divider masks for the half and eighth clocks
`define PWMT_DIV_HALF_MASK  3'h1
`define PWMT_DIV_EIGHT_MASK 3'h7

// Reset values
`define PWMT_RST_COUNT      8'hff
`define PWMT_RST_BYTE       8'h00
`define PWMT_RST_IRQ        2'h0
`define PWMT_RST_DIV        3'h0

`endif

// ### pwmt_cnt_src.v
// Count clock enable generator: picks one of four internal count clocks.
// Assumes the ring oscillator level is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"

module pwmt_cnt_src (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_b_i,
  // Source select and ring oscillator level
  input  wire [1:0] src_sel_i,
  input  wire       ring_osc_clock_i,
  // One-cycle count clock tick
  output reg        tick_o
);

  reg [2:0] div_ff;
  reg       ring_q_ff;
  reg       nxt_tick;

  // Source selection
  always @* begin
    case (src_sel_i)
      `PWMT_SRC_UNDIV:  nxt_tick = 1'b1;
      `PWMT_SRC_HALF:
        nxt_tick = ((div_ff & `PWMT_DIV_HALF_MASK) == `PWMT_RST_DIV);
      `PWMT_SRC_EIGHTH:
        nxt_tick = ((div_ff & `PWMT_DIV_EIGHT_MASK) == `PWMT_RST_DIV);
      default:          nxt_tick = ring_osc_clock_i & ~ring_q_ff;
    endcase
  end

  // Divider and edge detect
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_ff    <= `PWMT_RST_DIV;
      ring_q_ff <= 1'b0;
      tick_o    <= 1'b0;
    end else begin
      div_ff    <= div_ff + 3'h1;
      ring_q_ff <= ring_osc_clock_i;
      tick_o    <= nxt_tick;
    end
  end

endmodule // pwmt_cnt_src
`default_nettype wire

// ### pwmt_timer.v
// Pulse width measurement timer: 8-bit prescaler feeding 8-bit counter.
// Assumes a synchronous register port and pins synchronous to clk_i.
//
// Functional notes
// - Chain counts selected clock only while measured input sits at chosen level.
// - Main counter underflow reloads from its reload register and keeps counting.
// - Writing one to the run flag starts counting.
// - Writing zero to the run flag stops counting; counters hold values.
// - Every main counter underflow raises the timer interrupt.
// - Edge ending the measured level raises the external-pin interrupt.
// - Reading counter and prescaler returns their live counts.
// - Write while stopped loads both reload register and counter.
// - Write while counting: reload at next input, counter at second, resume third.
// - Polarity select picks high or low level periods for measurement.
// - Pin select routes measure pin a or b to the measurement input.
// - Selected pin carries the pulse and acts as external interrupt input.
// - Underflow rate is source over (prescaler+1)(counter+1).
// - Timer is stopped after reset; software loads values first.
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"

module pwmt_timer #(
  parameter ADDR_W = 4,
  parameter DATA_W = 8
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              rst_b_i,
  // Register port
  input  wire [ADDR_W-1:0] addr_i,
  input  wire [DATA_W-1:0] wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [DATA_W-1:0] rdata_o,
  // Measure pins and ring oscillator
  input  wire              measure_pin_a_i,
  input  wire              measure_pin_b_i,
  input  wire              ring_osc_clock_i,
  // Interrupt
  output reg               irq_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_XFER = 2'h2;

  reg                   pol_ff;
  reg                   run_ff;
  reg  [1:0]            src_ff;
  reg                   pin_sel_ff;
  reg  [DATA_W-1:0]     pre_cnt_ff;
  reg  [DATA_W-1:0]     pre_rld_ff;
  reg  [DATA_W-1:0]     pre_new_ff;
  reg  [1:0]            pre_st_ff;
  reg  [DATA_W-1:0]     main_cnt_ff;
  reg  [DATA_W-1:0]     main_rld_ff;
  reg  [DATA_W-1:0]     main_new_ff;
  reg  [1:0]            main_st_ff;
  reg                   meas_q_ff;
  reg  [`PWMT_IRQ_W-1:0] stat_ff;
  reg  [`PWMT_IRQ_W-1:0] en_ff;
  reg  [DATA_W-1:0]     nxt_rdata;
  reg  [DATA_W-1:0]     nxt_pre_cnt;
  reg  [DATA_W-1:0]     nxt_pre_rld;
  reg  [DATA_W-1:0]     nxt_pre_new;
  reg  [1:0]            nxt_pre_st;
  reg  [DATA_W-1:0]     nxt_main_cnt;
  reg  [DATA_W-1:0]     nxt_main_rld;
  reg  [DATA_W-1:0]     nxt_main_new;
  reg  [1:0]            nxt_main_st;

  wire                  src_tick;
  wire                  meas_in;
  wire                  level_on;
  wire                  cnt_tick;
  wire                  pre_uf;
  wire                  main_uf;
  wire                  end_edge;
  wire                  wr_mode;
  wire                  wr_pre;
  wire                  wr_main;
  wire                  wr_pincfg;
  wire                  wr_irq_clr;
  wire                  wr_irq_en;
  wire [`PWMT_IRQ_W-1:0] irq_evt;
  wire [`PWMT_IRQ_W-1:0] nxt_stat;
  wire [`PWMT_IRQ_W-1:0] nxt_en;
  wire                  nxt_irq;
  genvar                gi;

  // Address decode shared by read and write paths
  function hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  pwmt_cnt_src u_cnt_src (
    .clk_i            (clk_i),
    .rst_b_i          (rst_b_i),
    .src_sel_i        (src_ff),
    .ring_osc_clock_i (ring_osc_clock_i),
    .tick_o           (src_tick)
  );

  // Measurement input routing and level gate
  assign meas_in  = pin_sel_ff ? measure_pin_b_i : measure_pin_a_i;
  assign level_on = (meas_in == ~pol_ff);
  assign cnt_tick = src_tick & run_ff & level_on;
  // Edge that ends the measured level, on the same pin
  assign end_edge = (meas_q_ff == ~pol_ff) & ~level_on;
  // Chain underflows
  assign pre_uf   = cnt_tick & (pre_st_ff == ST_IDLE)
                  & (pre_cnt_ff == {DATA_W{1'b0}});
  assign main_uf  = pre_uf & (main_st_ff == ST_IDLE)
                  & (main_cnt_ff == {DATA_W{1'b0}});

  // Write decode
  assign wr_mode  = wr_i & hit(addr_i, `PWMT_ADDR_MODE);
  assign wr_pre   = wr_i & hit(addr_i, `PWMT_ADDR_PRESCALE);
  assign wr_main  = wr_i & hit(addr_i, `PWMT_ADDR_COUNTER);
  assign wr_pincfg  = wr_i & hit(addr_i, `PWMT_ADDR_PINCFG);
  assign wr_irq_clr = wr_i & hit(addr_i, `PWMT_ADDR_IRQ_CLR);
  assign wr_irq_en  = wr_i & hit(addr_i, `PWMT_ADDR_IRQ_EN);

  // Control registers
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      pol_ff     <= 1'b0;
      run_ff     <= 1'b0;
      src_ff     <= `PWMT_SRC_UNDIV;
      pin_sel_ff <= 1'b0;
      en_ff      <= `PWMT_RST_IRQ;
      meas_q_ff  <= 1'b0;
    end else begin
      meas_q_ff <= meas_in;
      if (wr_mode) begin
        pol_ff <= wdata_i[`PWMT_MODE_POL_BIT];
        run_ff <= wdata_i[`PWMT_MODE_RUN_BIT];
        src_ff <= wdata_i[`PWMT_MODE_SRC_MSB:`PWMT_MODE_SRC_LSB];
      end
      if (wr_pincfg)
        pin_sel_ff <= wdata_i[`PWMT_PINCFG_SEL_BIT];
      en_ff <= nxt_en;
    end
  end

  // Prescaler stage next values
  always @* begin
    nxt_pre_cnt = pre_cnt_ff;
    nxt_pre_rld = pre_rld_ff;
    nxt_pre_new = pre_new_ff;
    nxt_pre_st  = pre_st_ff;
    if (wr_pre && !run_ff) begin
      nxt_pre_cnt = wdata_i;
      nxt_pre_rld = wdata_i;
      nxt_pre_st  = ST_IDLE;
    end else if (wr_pre) begin
      nxt_pre_new = wdata_i;
      nxt_pre_st  = ST_LOAD;
    end else if (cnt_tick) begin
      case (pre_st_ff)
        ST_LOAD: begin
          nxt_pre_rld = pre_new_ff;
          nxt_pre_st  = ST_XFER;
        end
        ST_XFER: begin
          nxt_pre_cnt = pre_rld_ff;
          nxt_pre_st  = ST_IDLE;
        end
        default: begin
          if (pre_uf)
            nxt_pre_cnt = pre_rld_ff;
          else
            nxt_pre_cnt = pre_cnt_ff - {{(DATA_W-1){1'b0}}, 1'b1};
        end
      endcase
    end
  end

  // Prescaler stage registers
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      pre_cnt_ff <= `PWMT_RST_COUNT;
      pre_rld_ff <= `PWMT_RST_COUNT;
      pre_new_ff <= `PWMT_RST_COUNT;
      pre_st_ff  <= ST_IDLE;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      pre_rld_ff <= nxt_pre_rld;
      pre_new_ff <= nxt_pre_new;
      pre_st_ff  <= nxt_pre_st;
    end
  end

  // Main counter stage next values
  always @* begin
    nxt_main_cnt = main_cnt_ff;
    nxt_main_rld = main_rld_ff;
    nxt_main_new = main_new_ff;
    nxt_main_st  = main_st_ff;
    if (wr_main && !run_ff) begin
      nxt_main_cnt = wdata_i;
      nxt_main_rld = wdata_i;
      nxt_main_st  = ST_IDLE;
    end else if (wr_main) begin
      nxt_main_new = wdata_i;
      nxt_main_st  = ST_LOAD;
    end else if (cnt_tick) begin
      case (main_st_ff)
        ST_LOAD: begin
          nxt_main_rld = main_new_ff;
          nxt_main_st  = ST_XFER;
        end
        ST_XFER: begin
          nxt_main_cnt = main_rld_ff;
          nxt_main_st  = ST_IDLE;
        end
        default: begin
          if (main_uf)
            nxt_main_cnt = main_rld_ff;
          else if (pre_uf)
            nxt_main_cnt = main_cnt_ff - {{(DATA_W-1){1'b0}}, 1'b1};
        end
      endcase
    end
  end

  // Main counter stage registers
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      main_cnt_ff <= `PWMT_RST_COUNT;
      main_rld_ff <= `PWMT_RST_COUNT;
      main_new_ff <= `PWMT_RST_COUNT;
      main_st_ff  <= ST_IDLE;
    end else begin
      main_cnt_ff <= nxt_main_cnt;
      main_rld_ff <= nxt_main_rld;
      main_new_ff <= nxt_main_new;
      main_st_ff  <= nxt_main_st;
    end
  end

  // Sticky interrupt status; a set wins over a clear in the same cycle
  assign irq_evt[`PWMT_IRQ_UF_BIT]   = main_uf;
  assign irq_evt[`PWMT_IRQ_EDGE_BIT] = end_edge;
  generate
    for (gi = 0; gi < `PWMT_IRQ_W; gi = gi + 1) begin : g_stat
      assign nxt_stat[gi] = irq_evt[gi]
                          | (stat_ff[gi] & ~(wr_irq_clr & wdata_i[gi]));
    end
  endgenerate

  // Interrupt level follows the next status and enable together
  assign nxt_en  = wr_irq_en ? wdata_i[`PWMT_IRQ_W-1:0] : en_ff;
  assign nxt_irq = |(nxt_stat & nxt_en);

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      stat_ff <= `PWMT_RST_IRQ;
      irq_o   <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_o   <= nxt_irq;
    end
  end

  // Read path
  always @* begin
    nxt_rdata = `PWMT_RST_BYTE;
    if (hit(addr_i, `PWMT_ADDR_MODE)) begin
      nxt_rdata[`PWMT_MODE_POL_BIT] = pol_ff;
      nxt_rdata[`PWMT_MODE_RUN_BIT] = run_ff;
      nxt_rdata[`PWMT_MODE_SRC_MSB:`PWMT_MODE_SRC_LSB] = src_ff;
    end else if (hit(addr_i, `PWMT_ADDR_PRESCALE)) begin
      nxt_rdata = pre_cnt_ff;
    end else if (hit(addr_i, `PWMT_ADDR_COUNTER)) begin
      nxt_rdata = main_cnt_ff;
    end else if (hit(addr_i, `PWMT_ADDR_PINCFG)) begin
      nxt_rdata[`PWMT_PINCFG_SEL_BIT] = pin_sel_ff;
    end else if (hit(addr_i, `PWMT_ADDR_IRQ_STAT)) begin
      nxt_rdata[`PWMT_IRQ_W-1:0] = stat_ff;
    end else if (hit(addr_i, `PWMT_ADDR_IRQ_EN)) begin
      nxt_rdata[`PWMT_IRQ_W-1:0] = en_ff;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i)
      rdata_o <= `PWMT_RST_BYTE;
    else if (rd_i)
      rdata_o <= nxt_rdata;
    else
      rdata_o <= `PWMT_RST_BYTE;
  end

endmodule // pwmt_timer
`default_nettype wire

// ### pwmt_timer_asserts.sv
// Concurrent checks on the timer register port and interrupt output.
// Bound to every pwmt_timer; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"
module pwmt_chk #(
  parameter ADDR_W = 4,
  parameter DATA_W = 8
) (
  // Port of the timer
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence sq_stop;
    wr_i && addr_i == `PWMT_ADDR_MODE && !wdata_i[`PWMT_MODE_RUN_BIT];
  endsequence
  sequence sq_rd_cnt;
    rd_i && addr_i == `PWMT_ADDR_COUNTER;
  endsequence
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (rd_i && addr_i > `PWMT_ADDR_IRQ_EN
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  clear_read_a: assert property (rd_i && addr_i == `PWMT_ADDR_IRQ_CLR
    |=> rdata_o == 8'h00) else $error("clear register readable");
  irq_mask_a: assert property (wr_i && addr_i == `PWMT_ADDR_IRQ_EN
    && wdata_i[1:0] == 2'b00 |=> !irq_o) else $error("masked irq high");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_i) &&
    ($past(addr_i) == `PWMT_ADDR_IRQ_CLR ||
     $past(addr_i) == `PWMT_ADDR_IRQ_EN)) else $error("irq fell alone");
  irq_status_a: assert property (irq_o && rd_i &&
    addr_i == `PWMT_ADDR_IRQ_STAT |=> rdata_o != 8'h00)
    else $error("irq without status");
  mode_readback_a: assert property (wr_i && addr_i == `PWMT_ADDR_MODE
    ##1 rd_i && addr_i == `PWMT_ADDR_MODE
    |=> (rdata_o & 8'h0f) == ($past(wdata_i, 2) & 8'h0f))
    else $error("mode readback wrong");
  stopped_hold_a: assert property (sq_stop ##1 sq_rd_cnt ##1 sq_rd_cnt
    |=> rdata_o == $past(rdata_o)) else $error("count moved stopped");
endmodule // pwmt_chk
bind pwmt_timer pwmt_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) pwmt_chk_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// ### pwmt_pulse_src.sv
// Pulse source on the measure pins: one pulse of given width on demand.
// The unselected pin toggles every cycle to expose wrong routing.
`timescale 1ns/1ps
`default_nettype none
module pwmt_pulse_src (
  // Clock and pulse request
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       sel_i,
  input  wire logic       idle_i,
  input  wire logic [7:0] width_i,
  // Measure pins
  output wire logic       pin_a_o,
  output wire logic       pin_b_o
);
  logic       left_ff = 1'b0;
  logic [7:0] cnt_ff  = 8'h00;
  logic       wig_ff  = 1'b0;
  always @(posedge clk_i) begin
    wig_ff <= ~wig_ff;
    if (go_i) begin
      cnt_ff <= width_i;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
    left_ff <= go_i ? (width_i != 8'h00) : (cnt_ff > 8'h01);
  end
  assign pin_a_o = sel_i ? wig_ff : idle_i ^ left_ff;
  assign pin_b_o = sel_i ? idle_i ^ left_ff : wig_ff;
endmodule // pwmt_pulse_src
`default_nettype wire

// ### tb.sv
// Self-checking bench for pwmt_timer with a pulse source on its pins.
// Reads note expected data in a queue; a monitor compares.
`timescale 1ns/1ps
`default_nettype none
`include "pwmt_regs.vh"
module tb;
  logic       clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, rd_q = 0;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, width = 0, rdata_o;
  logic       go = 0, sel = 0, idle = 0, ring = 0, irq_o, pin_a, pin_b;
  logic [16:0] seed = 17'h1_752d;
  logic [7:0] q[$];
  logic [7:0] ticks[4] = '{8'h10, 8'h08, 8'h02, 8'h04};
  int         fails = 0, tests_run = 0, cyc = 0;
  always #2 clk_i = ~clk_i;
  pwmt_timer pwmt_timer_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .measure_pin_a_i(pin_a), .measure_pin_b_i(pin_b),
    .ring_osc_clock_i(ring), .irq_o(irq_o));
  pwmt_pulse_src pwmt_pulse_src_inst (.clk_i(clk_i), .go_i(go),
    .sel_i(sel), .idle_i(idle), .width_i(width), .pin_a_o(pin_a),
    .pin_b_o(pin_b));
  task chk(input [7:0] seen, input [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {2'b10, a, d};
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge clk_i);
    {wr_i, rd_i, addr_i} <= {2'b01, a};
    q.push_back(e);
  endtask
  task idle_n(input int n);
    repeat (n) begin
      @(posedge clk_i);
      {wr_i, rd_i, go} <= 3'b000;
    end
  endtask
  task pulse(input [7:0] w);
    @(posedge clk_i);
    {wr_i, rd_i, go, width} <= {3'b001, w};
    idle_n(w + 3);
  endtask
  task fin(input string s);
    idle_n(4);
    $display("test %s done", s);
  endtask
  function automatic [16:0] lfsr(input [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction
  always @(posedge clk_i) begin
    if (rd_q) chk(rdata_o, q.pop_front());
    rd_q <= rd_i;
    cyc <= cyc + 1;
    ring <= cyc[1];
    if (cyc == 3000) begin
      fails++;
      summarize;
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1;
    idle_n(1);
    rd(`PWMT_ADDR_MODE, 8'h00);
    rd(`PWMT_ADDR_COUNTER, `PWMT_RST_COUNT);
    rd(`PWMT_ADDR_IRQ_STAT, 8'h00);
    rd(`PWMT_ADDR_IRQ_CLR, 8'h00);
    rd(4'h7, 8'h00);
    seed = lfsr(seed);
    wr(`PWMT_ADDR_PRESCALE, seed[7:0]);
    rd(`PWMT_ADDR_PRESCALE, seed[7:0]);
    fin("reset");
    wr(`PWMT_ADDR_PRESCALE, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(`PWMT_ADDR_COUNTER, 8'hff);
      wr(`PWMT_ADDR_MODE, {4'h0, s[1:0], 2'b10});
      pulse(8'h10);
      rd(`PWMT_ADDR_COUNTER, 8'hff - ticks[s]);
      wr(`PWMT_ADDR_MODE, 8'h00);
    end
    fin("sources");
    wr(`PWMT_ADDR_IRQ_CLR, 8'h03);
    wr(`PWMT_ADDR_PRESCALE, 8'h01);
    wr(`PWMT_ADDR_COUNTER, 8'h01);
    wr(`PWMT_ADDR_IRQ_EN, 8'h01);
    wr(`PWMT_ADDR_MODE, 8'h02);
    pulse(8'h03);
    rd(`PWMT_ADDR_IRQ_STAT, 8'h02);
    rd(`PWMT_ADDR_COUNTER, 8'h00);
    idle_n(2);
    chk({7'h0, irq_o}, 8'h00);
    pulse(8'h01);
    chk({7'h0, irq_o}, 8'h01);
    rd(`PWMT_ADDR_IRQ_STAT, 8'h03);
    rd(`PWMT_ADDR_COUNTER, 8'h01);
    rd(`PWMT_ADDR_PRESCALE, 8'h01);
    wr(`PWMT_ADDR_IRQ_EN, 8'h00);
    idle_n(2);
    chk({7'h0, irq_o}, 8'h00);
    wr(`PWMT_ADDR_IRQ_CLR, 8'h03);
    rd(`PWMT_ADDR_IRQ_STAT, 8'h00);
    fin("underflow");
    wr(`PWMT_ADDR_MODE, 8'h00);
    rd(`PWMT_ADDR_COUNTER, 8'h01);
    rd(`PWMT_ADDR_COUNTER, 8'h01);
    pulse(8'h05);
    rd(`PWMT_ADDR_PRESCALE, 8'h01);
    wr(`PWMT_ADDR_PRESCALE, 8'h00);
    wr(`PWMT_ADDR_COUNTER, 8'hff);
    wr(`PWMT_ADDR_MODE, 8'h02);
    wr(`PWMT_ADDR_COUNTER, 8'h10);
    pulse(8'h01);
    rd(`PWMT_ADDR_COUNTER, 8'hff);
    pulse(8'h01);
    rd(`PWMT_ADDR_COUNTER, 8'h10);
    pulse(8'h01);
    rd(`PWMT_ADDR_COUNTER, 8'h0f);
    fin("stop and reload");
    wr(`PWMT_ADDR_MODE, 8'h00);
    {sel, idle} <= 2'b11;
    wr(`PWMT_ADDR_PINCFG, 8'h01);
    wr(`PWMT_ADDR_COUNTER, 8'hff);
    idle_n(3);
    wr(`PWMT_ADDR_IRQ_CLR, 8'h03);
    wr(`PWMT_ADDR_MODE, 8'h03);
    rd(`PWMT_ADDR_MODE, 8'h03);
    rd(`PWMT_ADDR_IRQ_STAT, 8'h00);
    pulse(8'h06);
    rd(`PWMT_ADDR_COUNTER, 8'hf9);
    rd(`PWMT_ADDR_IRQ_STAT, 8'h02);
    fin("polarity and pin");
    summarize;
  end
endmodule // tb
`default_nettype wire
